// *** verilog/chip_reset_sequencer.sv ***
/*
 * chip reset sequencer: merges five reset sources, times the release of
 * the internal reset and splits it into cold and warm domains.
 * assumes clk is the internal high-speed oscillator and rst is the raw
 * power-on detector output; the pin and analog sources are asynchronous.
 * assumes the watchdog and the processor request come from logic on clk,
 * so they pass no synchroniser; the cold output feeds only the debug
 * units and the flash security bit, the warm output everything else.
 * assumes software never relies on memory contents across any reset.
 */
// Summary of operation
// - reset asserts from power-on, pin, low voltage, watchdog, request
// - cause of the latest reset kept in readable cause flags
// - memory contents are not guaranteed across any reset
// - pin reset releases about 0.8 ms after pin returns high
// - power-on reset releases about 1.8 ms after supply in range
// - watchdog or request reset releases about 30 clocks after event
// - warm reset initialises processor and peripheral control registers
// - debug units and flash security bit reset only by cold reset
// - chip leaves reset running on internal high-speed oscillator
module chip_reset_sequencer
	import reset_seq_pkg::*;
(
	// clock and power-on reset
	input  wire logic               clk,
	input  wire logic               rst,
	// reset sources
	input  wire logic               reset_pin_n,
	input  wire logic               low_voltage_detector,
	input  wire logic               watchdog_timer,
	input  wire logic               system_reset_request,
	// resets to the chip
	output reset_out_type           reset_out,
	output logic                    ram_valid,
	// status
	output logic      [CAUSE_W-1:0] reset_cause_flags,
	output logic                    clock_select
);

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	logic [1:0] async_raw;
	logic [1:0] async_sync;
	source_type src;

	// pin and detector arrive from outside the clock domain
	assign async_raw = {low_voltage_detector, ~reset_pin_n};

	reset_sync #(
		.WIDTH(2)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (async_raw),
		.sync_out (async_sync)
	);

	// gather all sources; power-on is seen through rst itself
	always_comb begin
		src.power_on             = 1'b0;
		src.pin                  = async_sync[0];
		src.low_voltage_detector = async_sync[1];
		src.watchdog_timer       = watchdog_timer;
		src.system_reset_request = system_reset_request;
	end

	// ****************************************************************
	// release sequencer
	// ****************************************************************
	seq_state_type            state;
	seq_state_type            next_state;
	logic [COUNT_W-1:0]       count;
	logic [COUNT_W-1:0]       next_count;
	logic [CAUSE_W-1:0]       next_cause;
	logic                     cold_phase;
	logic                     next_cold_phase;
	logic                     any_src;
	logic [CAUSE_W-1:0]       new_cause;
	logic                     release_now;

	// any active source holds the chip in reset
	assign any_src = src.pin | src.low_voltage_detector
		| src.watchdog_timer | src.system_reset_request;

	// one cause bit for each active source, pin taking part too
	always_comb begin
		new_cause            = '0;
		new_cause[CAUSE_PIN] = src.pin;
		new_cause[CAUSE_LVD] = src.low_voltage_detector;
		new_cause[CAUSE_WDT] = src.watchdog_timer;
		new_cause[CAUSE_SYS] = src.system_reset_request;
	end

	// the count has run out with every source quiet
	assign release_now = (state == st_count) && !any_src
		&& (count <= COUNT_W'(1));

	// next state and delay count
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			st_hold: begin
				if (!any_src) begin
					next_state = st_count;
					next_count = release_count(reset_cause_flags);
				end
			end
			st_count: begin
				if (any_src) begin
					next_state = st_hold; // back to hold; the delay reloads in full once sources are quiet
				end else if (release_now) begin
					next_state = st_run;
					next_count = '0;
				end else begin
					next_count = count - COUNT_W'(1);
				end
			end
			st_run: begin
				if (any_src) begin
					next_state = st_hold;
				end
			end
			default: begin
				next_state = st_hold;
			end
		endcase
	end

	// register sequencer state; power-on forces the cold sequence
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= st_hold;
			count <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// ****************************************************************
	// reset cause flags
	// ****************************************************************
	logic                     enter_reset;

	// add the sources seen now to the flags kept so far
	function automatic logic [CAUSE_W-1:0] merge_cause(
		input logic [CAUSE_W-1:0] flags,
		input logic [CAUSE_W-1:0] fresh);
		return flags | fresh;
	endfunction : merge_cause

	// a fresh reset entry from run, as opposed to one already held
	assign enter_reset = (state == st_run) && any_src;

	// a fresh entry from run replaces the flags, a held one adds
	always_comb begin
		next_cause = reset_cause_flags;
		if (enter_reset) begin
			next_cause = new_cause; // latest reset replaces old cause
		end else if (any_src) begin
			next_cause = merge_cause(reset_cause_flags, new_cause);
		end
	end

	// register the flags; power-on is the cause after rst
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_cause_flags <= CAUSE_RESET;
		end else begin
			reset_cause_flags <= next_cause;
		end
	end

	// ****************************************************************
	// cold domain
	// ****************************************************************
	// cold phase ends at the first release after power-on
	always_comb begin
		next_cold_phase = cold_phase;
		if (release_now) begin
			next_cold_phase = 1'b0;
		end
	end

	// register the cold phase; only rst raises it again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cold_phase <= 1'b1;
		end else begin
			cold_phase <= next_cold_phase;
		end
	end

	// ****************************************************************
	// reset outputs
	// ****************************************************************
	reset_out_type next_reset_out;
	logic          next_ram_valid;
	logic          next_clock_select;

	// warm reset covers every sequence, cold only the power-on one
	always_comb begin
		next_reset_out.warm = (next_state != st_run);
		next_reset_out.cold = next_cold_phase;
		next_ram_valid      = 1'b0;
		next_clock_select   = CLK_SEL_INTERNAL;
	end

	// outputs held in flip-flops, asserted from power-on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_out    <= '{cold: 1'b1, warm: 1'b1};
			ram_valid    <= 1'b0;
			clock_select <= CLK_SEL_INTERNAL;
		end else begin
			reset_out    <= next_reset_out;
			ram_valid    <= next_ram_valid;
			clock_select <= next_clock_select;
		end
	end

endmodule : chip_reset_sequencer

// *** verilog/reset_seq_pkg.sv ***
/*
 * package for the chip reset sequencer: timing constants, cause flags,
 * sequencer states and the packed carriers shared by the two modules.
 * assumes a single 40 MHz clock that is the internal high-speed oscillator.
 */
package reset_seq_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_HZ          = 40000000;
	localparam int PIN_RELEASE_US  = 800;   // pin release delay, 0.8 ms
	localparam int POR_RELEASE_US  = 1800;  // power-on release delay, 1.8 ms
	localparam int SOFT_RELEASE_CY = 30;    // watchdog / request release
	localparam int PIN_MIN_LOW_CY  = 12;    // least warm pin low time
	localparam int PIN_RELEASE_CY  = (CLK_HZ / 1000) * PIN_RELEASE_US / 1000;
	localparam int POR_RELEASE_CY  = (CLK_HZ / 1000) * POR_RELEASE_US / 1000;
	localparam int COUNT_W         = 17;

	// ****************************************************************
	// cause flag positions and reset values
	// ****************************************************************
	localparam int CAUSE_W         = 5;
	localparam int CAUSE_POR       = 0;
	localparam int CAUSE_PIN       = 1;
	localparam int CAUSE_LVD       = 2;
	localparam int CAUSE_WDT       = 3;
	localparam int CAUSE_SYS       = 4;
	localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;
	localparam logic               CLK_SEL_INTERNAL = 1'b0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		st_hold    = 3'h1,
		st_count   = 3'h2,
		st_run     = 3'h4
	} seq_state_type;

	// raw reset requests from the five sources
	typedef struct packed {
		logic system_reset_request;
		logic watchdog_timer;
		logic low_voltage_detector;
		logic pin;
		logic power_on;
	} source_type;

	// reset outputs to the rest of the chip
	typedef struct packed {
		logic cold;      // cold-only domain reset
		logic warm;      // general reset
	} reset_out_type;

	// pick the release delay that the latest cause demands
	function automatic logic [COUNT_W-1:0] release_count(
		input logic [CAUSE_W-1:0] cause);
		if (cause[CAUSE_POR])
			return COUNT_W'(POR_RELEASE_CY);
		else if (cause[CAUSE_PIN] || cause[CAUSE_LVD])
			return COUNT_W'(PIN_RELEASE_CY);
		else
			return COUNT_W'(SOFT_RELEASE_CY);
	endfunction : release_count

endpackage : reset_seq_pkg

// *** verilog/reset_sync.sv ***
/*
 * two-stage synchroniser for a group of asynchronous level inputs.
 * assumes the inputs are static for at least two clock periods.
 */
module reset_sync
	import reset_seq_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	// next values of both stages
	always_comb begin
		next_stage1   = async_in;
		next_sync_out = stage1;
	end

	// register the stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= next_stage1;
			sync_out <= next_sync_out;
		end
	end

endmodule : reset_sync

// *** test/reset_seq_monitor.sv ***
/* checker bound to the reset sequencer ports.
   assumes reset_seq_pkg and a single clock domain. */
module reset_seq_monitor
	import reset_seq_pkg::*;
(
	// clock and reset
	input wire logic                clk,
	input wire logic                rst,
	// sources
	input wire logic                reset_pin_n,
	input wire logic                low_voltage_detector,
	input wire logic                watchdog_timer,
	input wire logic                system_reset_request,
	// outputs
	input wire reset_out_type       reset_out,
	input wire logic                ram_valid,
	input wire logic [CAUSE_W-1:0]  reset_cause_flags,
	input wire logic                clock_select
);
	// clocks since a soft source was last seen
	logic [5:0] quiet, next_quiet;
	always_comb next_quiet = (watchdog_timer | system_reset_request) ?
		6'h00 : quiet + {5'h00, ~&quiet};
	always_ff @(posedge clk or posedge rst) quiet <= rst ? 6'h3F : next_quiet;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// warm release after a soft-only cause
	sequence soft_fall;
		$fell(reset_out.warm) && reset_cause_flags[2:0] == 3'h0;
	endsequence
	sequence pin_low;
		!reset_pin_n ##1 !reset_pin_n;
	endsequence
	a_ram_not_kept: assert property (
		ram_valid == 1'b0) else $error("ram valid high");
	a_clock_internal: assert property (
		clock_select == CLK_SEL_INTERNAL) else $error("clock not internal");
	a_soft_asserts: assert property (
		watchdog_timer || system_reset_request |=> reset_out.warm)
		else $error("soft source no reset");
	a_pin_asserts: assert property (
		pin_low |-> ##[1:3] reset_out.warm) else $error("pin no reset");
	a_lowv_asserts: assert property (
		low_voltage_detector ##1 low_voltage_detector |-> ##[1:3]
		reset_out.warm) else $error("low voltage no reset");
	a_wdog_cause: assert property (
		!reset_out.warm && watchdog_timer && !system_reset_request |=>
		reset_cause_flags == 5'h08) else $error("watchdog cause wrong");
	a_req_cause: assert property (
		!reset_out.warm && system_reset_request && !watchdog_timer |=>
		reset_cause_flags == 5'h10) else $error("request cause wrong");
	a_soft_release: assert property (
		soft_fall |-> quiet inside {[6'h1A:6'h24]})
		else $error("soft release span wrong");
	a_cold_stays: assert property (
		!reset_out.cold |=> !reset_out.cold) else $error("cold reasserted");
	a_domains_drop: assert property (
		$fell(reset_out.cold) |-> $fell(reset_out.warm))
		else $error("cold fell alone");
endmodule : reset_seq_monitor

bind chip_reset_sequencer reset_seq_monitor mon (.clk(clk), .rst(rst),
	.reset_pin_n(reset_pin_n), .low_voltage_detector(low_voltage_detector),
	.watchdog_timer(watchdog_timer),
	.system_reset_request(system_reset_request), .reset_out(reset_out),
	.ram_valid(ram_valid), .reset_cause_flags(reset_cause_flags),
	.clock_select(clock_select));

// *** test/board_reset_driver.sv ***
/* board side reset driver: pulls the reset pin low on request.
   assumes a pull-up returns the pin high once released. */
module board_reset_driver (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// request
	input wire logic        pulse,
	input wire logic [7:0]  low_cy,
	// pin
	output logic            reset_pin_n
);
	// clocks left with the pin low, never under 12
	logic [7:0] left, next_left;
	always_comb next_left = pulse ? (low_cy < 8'h0C ? 8'h0C : low_cy) :
		left - {7'h00, |left};
	always_ff @(posedge clk or posedge rst) left <= rst ? 8'h00 : next_left;
	// low while power comes up, pull-up level once released
	assign reset_pin_n = ~(|left | rst);
endmodule : board_reset_driver

// *** test/testbench.sv ***
/* self-checking bench for the chip reset sequencer.
   assumes the board driver and the bound checker. */
module testbench
	import reset_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, lowv = 1'b0, wdog = 1'b0, sreq = 1'b0;
	logic pulse = 1'b0, ram_valid, clock_select, pin_n;
	logic [7:0] low_cy = 8'h0C;
	logic [1:0] sel;
	logic in_span;
	logic [CAUSE_W-1:0] cause;
	reset_out_type ro;
	int error_cnt = 0, checks_done = 0, seed = 32'h4143, n, k;
	always #12.5 clk = ~clk;
	board_reset_driver board (.clk(clk), .rst(rst), .pulse(pulse),
		.low_cy(low_cy), .reset_pin_n(pin_n));
	chip_reset_sequencer dut (.clk(clk), .rst(rst), .reset_pin_n(pin_n),
		.low_voltage_detector(lowv), .watchdog_timer(wdog),
		.system_reset_request(sreq), .reset_out(ro), .ram_valid(ram_valid),
		.reset_cause_flags(cause), .clock_select(clock_select));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// expected clocks from last source drop to release
	function automatic int rel_cy(logic [CAUSE_W-1:0] c);
		if (c[CAUSE_POR])
			return POR_RELEASE_CY + 1;
		if (c[CAUSE_PIN] | c[CAUSE_LVD])
			return PIN_RELEASE_CY + 3;
		return SOFT_RELEASE_CY + 1;
	endfunction : rel_cy
	// count clocks until warm reset drops
	task automatic span(logic [CAUSE_W-1:0] c);
		n = 0;
		while (ro.warm === 1'b1 && n < 80000) begin
			@(negedge clk);
			n++;
		end
		in_span = n >= rel_cy(c) - 4 && n <= rel_cy(c) + 4;
		check("span", in_span, 1'b1);
		check("cold", ro.cold, 1'b0);
	endtask : span
	// power-on, soft, pin and low voltage resets
	initial begin
		repeat (12) @(negedge clk);
		check("warm", ro.warm, 1'b1);
		check("cold", ro.cold, 1'b1);
		check("cause", cause, CAUSE_RESET);
		rst = 1'b0;
		span(CAUSE_RESET);
		for (int i = 0; i < 8; i++) begin
			sel = i < 3 ? 2'(3 - i) : 2'(1 + $unsigned($random(seed)) % 3);
			k = 1 + $unsigned($random(seed)) % 4;
			{sreq, wdog} = sel;
			@(negedge clk);
			check("warm", ro.warm, 1'b1);
			check("cause", cause, {sel, 3'h0});
			repeat (k - 1) @(negedge clk);
			{sreq, wdog} = 2'h0;
			if (i[0]) begin
				repeat (9) @(negedge clk);
				wdog = 1'b1;
				@(negedge clk);
				wdog = 1'b0;
			end
			span({sel, 3'h0});
			check("ram", ram_valid, 1'b0);
			check("osc", clock_select, CLK_SEL_INTERNAL);
			@(negedge clk);
		end
		pulse = 1'b1;
		@(negedge clk);
		pulse = 1'b0;
		repeat (6) @(negedge clk);
		check("warm", ro.warm, 1'b1);
		check("cause", cause, 5'h02);
		wait (pin_n === 1'b1);
		@(negedge clk);
		span(5'h02);
		lowv = 1'b1;
		repeat (4) @(negedge clk);
		check("warm", ro.warm, 1'b1);
		check("cause", cause, 5'h04);
		complete_run();
	end
	// hang guard
	initial begin
		#(25 * 110000);
		error_cnt++;
		complete_run();
	end
endmodule : testbench
